// File: core/fpc_coproc.sv
// Design decisions made here: the APB slave port and the address map.
`default_nettype none
module fpc_coproc #(
  parameter logic [15:0] EXEC_CYCLES = fpc_pkg::EXEC_CYCLES_DEF,
  parameter logic [15:0] DIAG_CYCLES = fpc_pkg::DIAG_CYCLES_DEF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Instruction issue
  input wire logic fp_instr_strobe_n,
  input wire logic [fpc_pkg::INSTR_W-1:0] host_instr_bits,
  output logic coproc_busy_n,
  // Faults from the arithmetic datapath and host interrupt state
  input wire logic fault_underflow,
  input wire logic fault_overflow,
  input wire logic fault_divzero,
  input wire logic host_int_disable,
  output logic fault_irq_req,
  // I/O skip test
  input wire logic io_skip,
  input wire logic [5:0] io_skip_dev,
  output logic skip_select_n,
  // Operand transfers
  input wire logic xfer_mem_n,
  input wire logic xfer_cpu_n,
  input wire logic xfer_to_host,
  input wire logic data_phase,
  input wire logic [0:15] read_data_in,
  input wire logic [0:15] addr_write_in,
  output logic [0:15] read_data_out,
  output logic read_data_oe,
  output logic [0:15] addr_write_out,
  output logic addr_write_oe
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    fpc_pkg::fpc_state_t state;
    logic [15:0] cnt;
    logic [fpc_pkg::INSTR_W-1:0] instr;
    logic pending;
    logic [63:0] float_accumulator;
    logic [63:0] temp;
    logic [63:0] work;
    logic [2:0] widx;
    logic [15:0] out_word;
    logic inhibit;
    logic [2:0] faults;
    logic diag_pass;
    logic [fpc_pkg::ST_WIDTH-1:0] status;
    logic [fpc_pkg::ST_WIDTH-1:0] mask;
  } fpc_st_t;

  fpc_st_t st_r;
  fpc_st_t st_nxt;

  // The check word is the pattern after the rotations done before the last diagnostic cycle.
  localparam int DIAG_ROT = (int'(DIAG_CYCLES) + 63) % 64;
  localparam logic [127:0] DIAG_TWICE = {fpc_pkg::DIAG_PATTERN, fpc_pkg::DIAG_PATTERN};

  fpc_cap_if cap_if ();

  fpc_strobe_capture u_cap (
    .pclk(pclk),
    .presetn(presetn),
    .fp_instr_strobe_n(fp_instr_strobe_n),
    .host_instr_bits(host_instr_bits),
    .cap(cap_if)
  );

  logic apb_wr;
  logic apb_rd;
  logic mapped;
  logic selected;
  logic to_mem;
  logic to_cpu;
  logic [2:0] words;
  logic [fpc_pkg::ST_WIDTH-1:0] events;
  logic [31:0] rd_mux;

  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & penable & ~pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= fpc_pkg::OFS_TEMP_LO);
  assign selected = ~xfer_mem_n | ~xfer_cpu_n;
  assign to_mem = ~xfer_mem_n;
  assign to_cpu = ~xfer_cpu_n & xfer_mem_n;
  assign words = st_r.instr[fpc_pkg::INSTR_PREC_BIT] ? fpc_pkg::WORDS_DOUBLE : fpc_pkg::WORDS_SINGLE;

  // ****************************************
  // Register read mux
  // ****************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      fpc_pkg::OFS_CTRL: rd_mux[fpc_pkg::CTRL_INHIBIT_BIT] = st_r.inhibit;
      fpc_pkg::OFS_STATUS: rd_mux[fpc_pkg::ST_WIDTH-1:0] = st_r.status;
      fpc_pkg::OFS_MASK: rd_mux[fpc_pkg::ST_WIDTH-1:0] = st_r.mask;
      fpc_pkg::OFS_STATE: begin
        rd_mux[fpc_pkg::INSTR_W-1:0] = st_r.instr;
        rd_mux[fpc_pkg::STATE_BUSY_BIT] = ~coproc_busy_n;
        rd_mux[fpc_pkg::STATE_PEND_BIT] = st_r.pending;
        rd_mux[fpc_pkg::STATE_PASS_BIT] = st_r.diag_pass;
      end
      fpc_pkg::OFS_FLOAT_ACCUMULATOR_HI: rd_mux = st_r.float_accumulator[63:32];
      fpc_pkg::OFS_FLOAT_ACCUMULATOR_LO: rd_mux = st_r.float_accumulator[31:0];
      fpc_pkg::OFS_TEMP_HI: rd_mux = st_r.temp[63:32];
      fpc_pkg::OFS_TEMP_LO: rd_mux = st_r.temp[31:0];
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    events = '0;
    if (cap_if.capture) begin
      st_nxt.instr = cap_if.bits;
      st_nxt.pending = 1'b1;
    end
    case (st_r.state)
      fpc_pkg::FPC_IDLE: begin
        if (st_r.pending && !cap_if.capture) begin
          st_nxt.pending = 1'b0;
          st_nxt.state = fpc_pkg::FPC_EXEC;
          st_nxt.cnt = EXEC_CYCLES - 16'h0001;
          st_nxt.widx = 3'h0;
        end else if (apb_wr && paddr == fpc_pkg::OFS_CTRL && pwdata[fpc_pkg::CTRL_DIAG_BIT]) begin
          st_nxt.state = fpc_pkg::FPC_DIAG;
          st_nxt.cnt = DIAG_CYCLES - 16'h0001;
          st_nxt.temp = fpc_pkg::DIAG_PATTERN;
        end
      end
      fpc_pkg::FPC_EXEC: begin
        if (st_r.cnt == 16'h0000) begin
          st_nxt.state = fpc_pkg::FPC_IDLE;
          events[fpc_pkg::ST_DONE] = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt - 16'h0001;
        end
      end
      fpc_pkg::FPC_DIAG: begin
        st_nxt.temp = {st_r.temp[62:0], st_r.temp[63]};
        if (st_r.cnt == 16'h0000) begin
          st_nxt.state = fpc_pkg::FPC_IDLE;
          st_nxt.temp = 64'h0;
          st_nxt.diag_pass = (st_r.temp == DIAG_TWICE[127 - DIAG_ROT -: 64]);
          events[fpc_pkg::ST_DIAG] = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt - 16'h0001;
        end
      end
      default: st_nxt.state = fpc_pkg::FPC_IDLE;
    endcase

    if (data_phase && selected && st_r.state != fpc_pkg::FPC_DIAG) begin
      if (!xfer_to_host) begin
        // first word holds sign and exponent
        st_nxt.work[63 - 16 * st_r.widx[1:0] -: 16] = to_mem ? read_data_in : addr_write_in;
        if (st_r.widx + 3'h1 == words) begin
          st_nxt.widx = 3'h0;
          st_nxt.temp = st_nxt.work;
          if (words == fpc_pkg::WORDS_SINGLE) begin
            st_nxt.temp[31:0] = 32'h0000_0000;
          end
        end else begin
          st_nxt.widx = st_r.widx + 3'h1;
        end
      end else begin
        st_nxt.widx = (st_r.widx + 3'h1 == words) ? 3'h0 : st_r.widx + 3'h1;
      end
    end
    // Result of a finished instruction lands in the accumulator.
    if (events[fpc_pkg::ST_DONE]) begin
      st_nxt.float_accumulator = st_r.temp;
    end
    st_nxt.out_word = st_nxt.float_accumulator[63 - 16 * st_nxt.widx[1:0] -: 16];

    events[fpc_pkg::ST_UNDERFLOW] = fault_underflow;
    events[fpc_pkg::ST_OVERFLOW] = fault_overflow;
    events[fpc_pkg::ST_DIVZERO] = fault_divzero;
    if (apb_wr && paddr == fpc_pkg::OFS_CTRL) begin
      st_nxt.inhibit = pwdata[fpc_pkg::CTRL_INHIBIT_BIT];
      if (pwdata[fpc_pkg::CTRL_FCLR_BIT]) begin
        st_nxt.faults = 3'h0;
      end
    end
    // A fault in the clearing cycle still stays latched.
    st_nxt.faults = st_nxt.faults | {fault_divzero, fault_overflow, fault_underflow};
    if (apb_wr && paddr == fpc_pkg::OFS_MASK) begin
      st_nxt.mask = pwdata[fpc_pkg::ST_WIDTH-1:0];
    end
    if (apb_rd && paddr == fpc_pkg::OFS_STATUS) begin
      st_nxt.status = '0;
    end
    st_nxt.status = st_nxt.status | events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.state <= fpc_pkg::FPC_IDLE;
      st_r.mask <= fpc_pkg::MASK_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // APB answers with no wait states; a bad address only flags the error.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = apb_rd ? rd_mux : 32'h0000_0000;
  assign irq = |(st_r.status & st_r.mask);
  assign coproc_busy_n = (st_r.state == fpc_pkg::FPC_IDLE);
  assign fault_irq_req = (|st_r.faults) & ~host_int_disable & ~st_r.inhibit;
  assign skip_select_n = ~(io_skip && io_skip_dev == fpc_pkg::DEV_CODE && (|st_r.faults));
  assign read_data_out = st_r.out_word;
  assign addr_write_out = st_r.out_word;
  assign read_data_oe = data_phase & xfer_to_host & to_cpu;
  assign addr_write_oe = data_phase & xfer_to_host & to_mem;
  // lines 16-20 have no driver here; the bus port is 16 bits only.
endmodule
`default_nettype wire

// File: core/fpc_pkg.sv
`default_nettype none
package fpc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  localparam logic [7:0] OFS_FLOAT_ACCUMULATOR_HI = 8'h10;
  localparam logic [7:0] OFS_FLOAT_ACCUMULATOR_LO = 8'h14;
  localparam logic [7:0] OFS_TEMP_HI = 8'h18;
  localparam logic [7:0] OFS_TEMP_LO = 8'h1c;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_DIAG_BIT = 0;
  localparam int CTRL_FCLR_BIT = 1;
  localparam int CTRL_INHIBIT_BIT = 13;
  localparam int ST_UNDERFLOW = 0;
  localparam int ST_OVERFLOW = 1;
  localparam int ST_DIVZERO = 2;
  localparam int ST_DONE = 3;
  localparam int ST_DIAG = 4;
  localparam int ST_WIDTH = 5;
  localparam int STATE_BUSY_BIT = 16;
  localparam int STATE_PEND_BIT = 17;
  localparam int STATE_PASS_BIT = 18;
  // Instruction register holds host bits 1,2,5-9,14,15 in that order, MSB first.
  localparam int INSTR_W = 9;
  localparam int INSTR_PREC_BIT = 6;
  // ****************************************
  // Reset values, codes and counts
  // ****************************************
  localparam logic [ST_WIDTH-1:0] MASK_RESET = 5'h00;
  localparam logic [5:0] DEV_CODE = 6'h3e;
  localparam logic [2:0] WORDS_SINGLE = 3'h2;
  localparam logic [2:0] WORDS_DOUBLE = 3'h4;
  localparam logic [63:0] DIAG_PATTERN = 64'ha55a_3cc3_0ff0_9669;
  localparam logic [15:0] EXEC_CYCLES_DEF = 16'h0010;
  localparam logic [15:0] DIAG_CYCLES_DEF = 16'h0040;
  typedef enum logic [1:0] {
    FPC_IDLE = 2'b00,
    FPC_EXEC = 2'b01,
    FPC_DIAG = 2'b10
  } fpc_state_t;
endpackage
`default_nettype wire

// File: core/fpc_cap_if.sv
`default_nettype none
interface fpc_cap_if;
  logic capture;
  logic [fpc_pkg::INSTR_W-1:0] bits;
  modport src (output capture, output bits);
  modport dst (input capture, input bits);
endinterface
`default_nettype wire

// File: core/fpc_strobe_capture.sv
`default_nettype none
module fpc_strobe_capture (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Host pins
  input wire logic fp_instr_strobe_n,
  input wire logic [fpc_pkg::INSTR_W-1:0] host_instr_bits,
  // Toward the control processor
  fpc_cap_if.src cap
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic capture;
    logic [fpc_pkg::INSTR_W-1:0] bits;
  } fpc_cap_st_t;

  fpc_cap_st_t st_r;
  fpc_cap_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = ~fp_instr_strobe_n;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.capture = st_r.s2 & ~st_r.s3;
    if (st_r.s2 & ~st_r.s3) begin
      st_nxt.bits = host_instr_bits;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cap.capture = st_r.capture;
  assign cap.bits = st_r.bits;
endmodule
`default_nettype wire

// File: verification/fpc_coproc_properties.sv
`default_nettype none
module fpc_coproc_properties #(
  parameter logic [15:0] EXEC_CYCLES = fpc_pkg::EXEC_CYCLES_DEF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Watched ports
  input wire logic fp_instr_strobe_n,
  input wire logic coproc_busy_n,
  input wire logic fault_underflow,
  input wire logic fault_overflow,
  input wire logic fault_divzero,
  input wire logic host_int_disable,
  input wire logic fault_irq_req,
  input wire logic io_skip,
  input wire logic [5:0] io_skip_dev,
  input wire logic skip_select_n,
  input wire logic data_phase,
  input wire logic xfer_to_host,
  input wire logic read_data_oe,
  input wire logic addr_write_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // Helpers
  // ********
  logic [15:0] busy_cnt_r;
  logic strobe_q_r;
  logic queued_r;
  logic any_fault;
  assign any_fault = fault_underflow | fault_overflow | fault_divzero;
  // Remembers a strobe that fell while busy, so its deferred decode can be checked.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt_r <= 16'h0000;
      strobe_q_r <= 1'b1;
      queued_r <= 1'b0;
    end else begin
      busy_cnt_r <= coproc_busy_n ? 16'h0000 : busy_cnt_r + 16'h0001;
      strobe_q_r <= fp_instr_strobe_n;
      if (strobe_q_r && !fp_instr_strobe_n && !coproc_busy_n) begin
        queued_r <= 1'b1;
      end else if (coproc_busy_n) begin
        queued_r <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence issue_idle_s;
    $fell(fp_instr_strobe_n) && coproc_busy_n;
  endsequence
  sequence busy_end_s;
    $rose(coproc_busy_n);
  endsequence
  busy_answer_a: assert property (issue_idle_s |-> ##[1:6] !coproc_busy_n)
    else $error("busy not raised after strobe");
  busy_hold_a: assert property ($fell(coproc_busy_n) |=> !coproc_busy_n [*8])
    else $error("busy released too early");
  exec_length_a: assert property (busy_end_s |-> busy_cnt_r >= EXEC_CYCLES - 16'h0001 &&
    busy_cnt_r <= EXEC_CYCLES + 16'h0001) else $error("busy length wrong");
  decode_gap_a: assert property (busy_end_s ##0 queued_r |-> ##[1:4] !coproc_busy_n)
    else $error("queued instruction not decoded after release");
  irq_enable_a: assert property (fault_irq_req |-> !host_int_disable)
    else $error("fault request while host disabled");
  skip_device_a: assert property (!skip_select_n |-> io_skip && io_skip_dev == fpc_pkg::DEV_CODE)
    else $error("skip answered wrong device");
  skip_fault_a: assert property (any_fault ##1 (io_skip && io_skip_dev == fpc_pkg::DEV_CODE) |-> !skip_select_n)
    else $error("skip missing after fault");
  oe_phase_a: assert property (read_data_oe || addr_write_oe |-> data_phase && xfer_to_host)
    else $error("bus driven outside data phase");
  oe_single_a: assert property (read_data_oe |-> !addr_write_oe)
    else $error("both buses driven");
endmodule
bind fpc_coproc fpc_coproc_properties #(.EXEC_CYCLES(EXEC_CYCLES)) u_props (
  .pclk, .presetn, .fp_instr_strobe_n, .coproc_busy_n, .fault_underflow, .fault_overflow, .fault_divzero,
  .host_int_disable, .fault_irq_req, .io_skip, .io_skip_dev, .skip_select_n, .data_phase, .xfer_to_host,
  .read_data_oe, .addr_write_oe
);
`default_nettype wire

// File: verification/fpc_host_model.sv
`default_nettype none
module fpc_host_model (
  // Clock and busy line
  input wire logic pclk,
  input wire logic coproc_busy_n,
  // Design answers on the shared buses
  input wire logic [0:15] read_data_out,
  input wire logic [0:15] addr_write_out,
  input wire logic read_data_oe,
  input wire logic addr_write_oe,
  // Host driven pins
  output logic fp_instr_strobe_n,
  output logic [fpc_pkg::INSTR_W-1:0] host_instr_bits,
  output logic xfer_mem_n,
  output logic xfer_cpu_n,
  output logic xfer_to_host,
  output logic data_phase,
  output logic [0:15] read_data_in,
  output logic [0:15] addr_write_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    fp_instr_strobe_n = 1'b1;
    host_instr_bits = '0;
    {xfer_mem_n, xfer_cpu_n, xfer_to_host, data_phase} = 4'hc;
    read_data_in = 16'h0000;
    addr_write_in = 16'h0000;
  end
  task automatic issue(input logic [fpc_pkg::INSTR_W-1:0] bits);
    @(posedge pclk);
    host_instr_bits <= bits;
    fp_instr_strobe_n <= 1'b0;
    repeat (5) @(posedge pclk);
    fp_instr_strobe_n <= 1'b1;
    host_instr_bits <= ~bits;
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 8 && coproc_busy_n === 1'b1; n++)
      @(negedge pclk);
    for (int n = 0; n < 200 && coproc_busy_n !== 1'b1; n++)
      @(negedge pclk);
  endtask
  task automatic move(input logic mem, input logic send, input logic [0:15] w, output logic [17:0] seen);
    @(posedge pclk);
    {xfer_mem_n, xfer_cpu_n, xfer_to_host, data_phase} <= {!mem, mem, send, 1'b1};
    read_data_in <= w;
    addr_write_in <= w;
    // Enables and the outgoing word are taken mid-cycle, where they have settled.
    @(negedge pclk);
    seen = {read_data_oe, addr_write_oe, mem ? addr_write_out : read_data_out};
    @(posedge pclk);
    {xfer_mem_n, xfer_cpu_n, xfer_to_host, data_phase} <= 4'hc;
    read_data_in <= ~w;
    addr_write_in <= ~w;
  endtask
endmodule
`default_nettype wire

// File: verification/tb_fpc_coproc.sv
`default_nettype none
module tb_fpc_coproc;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic fp_instr_strobe_n, coproc_busy_n, fault_underflow, fault_overflow, fault_divzero;
  logic host_int_disable, fault_irq_req, io_skip, skip_select_n;
  logic xfer_mem_n, xfer_cpu_n, xfer_to_host, data_phase, read_data_oe, addr_write_oe;
  logic [5:0] io_skip_dev;
  logic [fpc_pkg::INSTR_W-1:0] host_instr_bits;
  logic [0:15] read_data_in, addr_write_in, read_data_out, addr_write_out;
  int fail_count = 0;
  int total_checks = 0;
  fpc_coproc #(.EXEC_CYCLES(16'h0020), .DIAG_CYCLES(16'h0020)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .fp_instr_strobe_n, .host_instr_bits, .coproc_busy_n, .fault_underflow, .fault_overflow,
    .fault_divzero, .host_int_disable, .fault_irq_req, .io_skip, .io_skip_dev, .skip_select_n,
    .xfer_mem_n, .xfer_cpu_n, .xfer_to_host, .data_phase, .read_data_in, .addr_write_in,
    .read_data_out, .addr_write_out, .read_data_oe, .addr_write_oe
  );
  fpc_host_model host (
    .pclk, .coproc_busy_n, .read_data_out, .addr_write_out, .read_data_oe, .addr_write_oe,
    .fp_instr_strobe_n, .host_instr_bits, .xfer_mem_n, .xfer_cpu_n,
    .xfer_to_host, .data_phase, .read_data_in, .addr_write_in
  );
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ********
  // Bus cycles
  // ********
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] r);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge pclk);
    r = {pslverr, prdata};
    {psel, penable} <= 2'b00;
    if (n == 20) begin
      fail_count++;
      $display("MISMATCH %0t bus answer timed out", $time);
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic chk(input logic [7:0] a, input logic [32:0] exp);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    cmp(r[31:0], exp[31:0]);
    cmp(32'(r[32]), 32'(exp[32]));
  endtask
  task automatic idle();
    host.wait_idle();
    if (coproc_busy_n !== 1'b1) begin
      fail_count++;
      $display("MISMATCH %0t busy never released", $time);
      complete_run();
    end
  endtask
  initial begin
    logic [32:0] r;
    logic [17:0] s;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {fault_underflow, fault_overflow, fault_divzero, host_int_disable, io_skip, io_skip_dev} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(fpc_pkg::OFS_STATUS, 33'h0);
    chk(fpc_pkg::OFS_MASK, 33'h0);
    chk(fpc_pkg::OFS_STATE, 33'h0);
    chk(8'h20, 33'h1_0000_0000);
    $display("Test reset done");
    host.issue(9'h0a5);
    chk(fpc_pkg::OFS_STATE, 33'h0_0001_00a5);
    host.issue(9'h14c);
    chk(fpc_pkg::OFS_STATE, 33'h0_0003_014c);
    idle();
    idle();
    chk(fpc_pkg::OFS_STATUS, 33'h8);
    $display("Test issue done");
    host.move(1'b0, 1'b0, 16'h4123, s);
    cmp(32'(s[17:16]), 32'h0);
    host.move(1'b0, 1'b0, 16'h4567, s);
    host.move(1'b0, 1'b0, 16'h89ab, s);
    host.move(1'b0, 1'b0, 16'hcdef, s);
    chk(fpc_pkg::OFS_TEMP_HI, 33'h4123_4567);
    chk(fpc_pkg::OFS_TEMP_LO, 33'h89ab_cdef);
    host.issue(9'h0a5);
    idle();
    chk(fpc_pkg::OFS_FLOAT_ACCUMULATOR_HI, 33'h4123_4567);
    chk(fpc_pkg::OFS_FLOAT_ACCUMULATOR_LO, 33'h89ab_cdef);
    chk(fpc_pkg::OFS_STATUS, 33'h8);
    host.move(1'b1, 1'b0, 16'hc1d2, s);
    host.move(1'b1, 1'b0, 16'h0e3f, s);
    chk(fpc_pkg::OFS_TEMP_HI, 33'hc1d2_0e3f);
    chk(fpc_pkg::OFS_TEMP_LO, 33'h0);
    host.move(1'b0, 1'b1, 16'h0000, s);
    cmp(32'(s), 32'h0002_4123);
    host.move(1'b1, 1'b1, 16'h0000, s);
    cmp(32'(s), 32'h0001_4567);
    $display("Test transfer done");
    wr(fpc_pkg::OFS_MASK, 32'h7);
    io_skip <= 1'b1;
    io_skip_dev <= fpc_pkg::DEV_CODE;
    for (int i = 0; i < 3; i++) begin
      {fault_divzero, fault_overflow, fault_underflow} <= 3'(1 << i);
      @(posedge pclk);
      {fault_divzero, fault_overflow, fault_underflow} <= 3'h0;
      @(posedge pclk);
      cmp(32'({fault_irq_req, irq, skip_select_n}), 32'h6);
      host_int_disable <= 1'b1;
      io_skip_dev <= 6'h3d;
      repeat (2) @(posedge pclk);
      cmp(32'({fault_irq_req, skip_select_n}), 32'h1);
      host_int_disable <= 1'b0;
      io_skip_dev <= fpc_pkg::DEV_CODE;
      chk(fpc_pkg::OFS_STATUS, 33'(1 << i));
      chk(fpc_pkg::OFS_STATUS, 33'h0);
      wr(fpc_pkg::OFS_CTRL, 32'h2000);
      @(posedge pclk);
      cmp(32'({fault_irq_req, irq, skip_select_n}), 32'h0);
      wr(fpc_pkg::OFS_CTRL, 32'h2002);
      wr(fpc_pkg::OFS_CTRL, 32'h0);
      @(posedge pclk);
      cmp(32'({fault_irq_req, irq, skip_select_n}), 32'h1);
    end
    $display("Test fault done");
    wr(fpc_pkg::OFS_CTRL, 32'h1);
    r = '0;
    for (int n = 0; n < 100 && r[4] !== 1'b1; n++)
      apb(1'b0, fpc_pkg::OFS_STATUS, 32'h0, r);
    cmp(32'(r[4]), 32'h1);
    chk(fpc_pkg::OFS_STATE, 33'h0_0004_00a5);
    chk(fpc_pkg::OFS_TEMP_HI, 33'h0);
    $display("Test diagnostic done");
    complete_run();
  end
endmodule
`default_nettype wire
